// [common/rq_pkg.sv]
package rq_pkg;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int QDEPTH = 64;
    localparam int LDEPTH = 16;
    localparam int LWIDTH = 9;

    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [6:0] A_STAT1  = 7'h03;
    localparam logic [6:0] A_STAT2  = 7'h04;
    localparam logic [6:0] A_IEN1   = 7'h05;
    localparam logic [6:0] A_IEN2   = 7'h06;
    localparam logic [6:0] A_OPMODE = 7'h07;
    localparam logic [6:0] A_MCTL2  = 7'h08;
    localparam logic [6:0] A_PKLEN  = 7'h3E;
    localparam logic [6:0] A_RXTHR  = 7'h71;
    localparam logic [6:0] A_TXHI   = 7'h7C;
    localparam logic [6:0] A_TXLO   = 7'h7D;
    localparam logic [6:0] A_QDATA  = 7'h7F;

    // ----------------------------------------
    // values after reset
    // ----------------------------------------
    localparam logic [7:0] R_MCTL2  = 8'h00;
    localparam logic [7:0] R_OPMODE = 8'h00;
    localparam logic [5:0] R_RXTHR  = 6'h37;
    localparam logic [5:0] R_TXHI   = 6'h37;
    localparam logic [5:0] R_TXLO   = 6'h04;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int B_TXFLUSH = 0;
    localparam int B_RXFLUSH = 1;
    localparam int B_EXIT    = 3;
    localparam int B_READY   = 0;
    localparam int B_TXON    = 3;
    localparam int B_TXAF    = 6;
    localparam int B_TXAE    = 5;
    localparam int B_RXAF    = 4;
    localparam int B_PKSENT  = 2;
    localparam int B_TXEXIT  = 7;

    typedef enum logic [1:0] {ST_STANDBY, ST_READY, ST_TX} rq_radio_t;
endpackage

// [common/rq_stream_if.sv]
interface rq_stream_if #(parameter int W = rq_pkg::LWIDTH);
    logic         w_valid;
    logic         w_ready;
    logic [W-1:0] w_data;
    logic         r_valid;
    logic         r_ready;
    logic [W-1:0] r_data;

    modport fifo (input w_valid, w_data, r_ready, output w_ready, r_valid, r_data);
    modport user (output w_valid, w_data, r_ready, input w_ready, r_valid, r_data);
endinterface

// [hdl/rq_link_fifo.sv]
module rq_link_fifo #(
    parameter int WIDTH = rq_pkg::LWIDTH,
    parameter int DEPTH = rq_pkg::LDEPTH
) (
    // write side, link clock
    input  wire logic  wclk,
    input  wire logic  wrst_n,
    // read side, core clock
    input  wire logic  rclk,
    input  wire logic  rrst_n,
    // both streams
    rq_stream_if.fifo  q
);
    localparam int AW = $clog2(DEPTH);

    // gray pointers need at least two address bits
    if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_chk
        $error("depth must be a power of two, at least 4");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 bin;
        logic [AW:0]                 gray;
        logic [AW:0]                 s1;
        logic [AW:0]                 s2;
    } rq_wside_t;

    typedef struct packed {
        logic [AW:0] bin;
        logic [AW:0] gray;
        logic [AW:0] s1;
        logic [AW:0] s2;
    } rq_rside_t;

    rq_wside_t w, wn;
    rq_rside_t r, rn;

    // full: far pointer one lap behind, top two gray bits inverted
    assign q.w_ready = (w.gray != {~w.s2[AW:AW-1], w.s2[AW-2:0]});
    assign q.r_valid = (r.gray != r.s2);
    assign q.r_data  = w.mem[r.bin[AW-1:0]];

    // write side: store, advance, sync read pointer
    always_comb begin
        wn    = w;
        wn.s1 = r.gray;
        wn.s2 = w.s1;
        if (q.w_valid && q.w_ready) begin
            wn.mem[w.bin[AW-1:0]] = q.w_data;
            wn.bin                = w.bin + 1'b1;
            wn.gray               = wn.bin ^ (wn.bin >> 1);
        end
    end

    always_ff @(posedge wclk or negedge wrst_n) begin
        if (!wrst_n) begin
            w <= '0;
        end else begin
            w <= wn;
        end
    end

    // read side: advance, sync write pointer
    always_comb begin
        rn    = r;
        rn.s1 = w.gray;
        rn.s2 = r.s1;
        if (q.r_valid && q.r_ready) begin
            rn.bin  = r.bin + 1'b1;
            rn.gray = rn.bin ^ (rn.bin >> 1);
        end
    end

    always_ff @(posedge rclk or negedge rrst_n) begin
        if (!rrst_n) begin
            r <= '0;
        end else begin
            r <= rn;
        end
    end
endmodule // rq_link_fifo

// [hdl/rq_byte_queues.sv]
module rq_byte_queues #(
    parameter int QUEUE_DEPTH = rq_pkg::QDEPTH,
    parameter int LINK_DEPTH  = rq_pkg::LDEPTH
) (
    // core clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // serial register port
    input  wire logic        sck,
    input  wire logic        sel_n,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             sdo_oe,
    // modem side
    input  wire logic        mod_tx_take,
    output logic [7:0]       mod_tx_data,
    output logic             mod_tx_valid,
    input  wire logic        mod_rx_push,
    input  wire logic [7:0]  mod_rx_data,
    // status
    output logic [1:0]       radio_state,
    output logic             interrupt_line_n
);
    localparam int PW = $clog2(QUEUE_DEPTH);
    localparam int CW = PW + 1;

    // thresholds are six bits, so deeper queues could not be served
    if (QUEUE_DEPTH < 2 || QUEUE_DEPTH > 64 || (1 << PW) != QUEUE_DEPTH) begin : g_chk
        $error("queue depth must be a power of two up to 64");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [6:0] shin;
        logic [7:0] shout;
        logic       addr_done;
        logic       sdo;
        logic       oe;
    } rq_link_t;

    typedef struct packed {
        logic [QUEUE_DEPTH-1:0][7:0] txq;
        logic [QUEUE_DEPTH-1:0][7:0] rxq;
        logic [PW-1:0]               txwp;
        logic [PW-1:0]               txrp;
        logic [PW-1:0]               rxwp;
        logic [PW-1:0]               rxrp;
        logic [CW-1:0]               txcnt;
        logic [CW-1:0]               rxcnt;
        logic [6:0]                  addr;
        logic                        wr;
        logic [7:0]                  rd_byte;
        logic [7:0]                  stat1;
        logic [7:0]                  stat2;
        logic [7:0]                  ien1;
        logic [7:0]                  ien2;
        logic [7:0]                  opmode;
        logic [7:0]                  mctl2;
        logic [7:0]                  pklen;
        logic [5:0]                  rxthr;
        logic [5:0]                  txhi;
        logic [5:0]                  txlo;
        logic [7:0]                  sent;
        rq_pkg::rq_radio_t           st;
        logic [7:0]                  txd;
        logic                        txv;
        logic                        irq_n;
    } rq_core_t;

    rq_link_t          l, ln;
    rq_core_t          c, cn;
    logic              frame_rst_n;
    logic              done;
    logic [7:0]        byte_in;
    logic [7:0]        wd;
    logic              wfirst;
    logic              tx_full;
    logic              tx_wr;
    logic              mode_wr;
    logic              stall;
    logic              take;
    logic              prep;
    logic              pk_end;
    logic              push_tx;
    logic              pop_tx;
    logic              push_rx;
    logic              pop_rx;
    logic [6:0]        na;
    logic [7:0]        set1;
    logic [7:0]        set2;
    logic [7:0]        clr1;
    logic [7:0]        clr2;
    rq_pkg::rq_radio_t idle_st;

    rq_stream_if #(.W(rq_pkg::LWIDTH)) bus ();

    // ----------------------------------------
    // link side, runs on the serial clock
    // ----------------------------------------
    // frame logic restarts whenever select is released
    assign frame_rst_n = reset_n & ~sel_n;
    assign done        = (l.bit_cnt == 3'h7);
    assign byte_in     = {l.shin, sdi};
    assign bus.w_valid = done;
    assign bus.w_data  = {~l.addr_done, byte_in};

    // shifter; a full link buffer freezes the last bit until space opens
    always_comb begin
        ln = l;
        if (!done || bus.w_ready) begin
            ln.bit_cnt = l.bit_cnt + 3'h1;
            ln.shin    = byte_in[6:0];
            // read byte is held still by the core until the host clocks it
            if (l.bit_cnt == 3'h0) begin
                ln.sdo   = c.rd_byte[7];
                ln.shout = {c.rd_byte[6:0], 1'b0};
            end else begin
                ln.sdo   = l.shout[7];
                ln.shout = {l.shout[6:0], 1'b0};
            end
            if (done && !l.addr_done) begin
                ln.addr_done = 1'b1;
                ln.oe        = ~byte_in[7];
            end
        end
    end

    always_ff @(posedge sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            l <= '0;
        end else begin
            l <= ln;
        end
    end

    rq_link_fifo #(
        .WIDTH (rq_pkg::LWIDTH),
        .DEPTH (LINK_DEPTH)
    ) u_link_fifo (
        .wclk   (sck),
        .wrst_n (reset_n),
        .rclk   (clk),
        .rrst_n (reset_n),
        .q      (bus.fifo)
    );

    // ----------------------------------------
    // register read mux
    // ----------------------------------------
    function automatic logic [7:0] reg_read(input rq_core_t s, input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            rq_pkg::A_STAT1:  v = s.stat1;
            rq_pkg::A_STAT2:  v = s.stat2;
            rq_pkg::A_IEN1:   v = s.ien1;
            rq_pkg::A_IEN2:   v = s.ien2;
            rq_pkg::A_OPMODE: v = s.opmode;
            rq_pkg::A_MCTL2:  v = s.mctl2;
            rq_pkg::A_PKLEN:  v = s.pklen;
            rq_pkg::A_RXTHR:  v = {2'b00, s.rxthr};
            rq_pkg::A_TXHI:   v = {2'b00, s.txhi};
            rq_pkg::A_TXLO:   v = {2'b00, s.txlo};
            rq_pkg::A_QDATA:  v = (s.rxcnt != '0) ? s.rxq[s.rxrp] : 8'h00;
            default:          v = 8'h00;
        endcase
        return v;
    endfunction

    // ----------------------------------------
    // core side
    // ----------------------------------------
    assign idle_st = c.opmode[rq_pkg::B_READY] ? rq_pkg::ST_READY : rq_pkg::ST_STANDBY;
    assign wd      = bus.r_data[7:0];
    assign wfirst  = bus.r_data[8];
    assign tx_full = (c.txcnt == CW'(QUEUE_DEPTH));
    assign tx_wr   = bus.r_valid && !wfirst && c.wr && (c.addr == rq_pkg::A_QDATA);
    // hold a full-queue write while sending frees room; otherwise it is dropped
    assign stall   = tx_wr && tx_full && (c.st == rq_pkg::ST_TX);
    assign take    = bus.r_valid && !stall;
    assign mode_wr = take && !wfirst && c.wr && (c.addr == rq_pkg::A_OPMODE);
    assign bus.r_ready = !stall;

    // sequencing, word handling, queues and flags
    always_comb begin
        cn      = c;
        cn.txv  = 1'b0;
        push_tx = 1'b0;
        pop_tx  = 1'b0;
        push_rx = 1'b0;
        pop_rx  = 1'b0;
        pk_end  = 1'b0;
        prep    = 1'b0;
        na      = c.addr;
        set1    = 8'h00;
        set2    = 8'h00;
        clr1    = 8'h00;
        clr2    = 8'h00;
        unique case (c.st)
            rq_pkg::ST_TX: begin
                if (c.pklen != 8'h00 && c.sent == c.pklen) begin
                    pk_end = 1'b1;
                    cn.st = idle_st;
                    cn.opmode[rq_pkg::B_TXON] = 1'b0;
                    set1[rq_pkg::B_PKSENT] = 1'b1;
                end else if (c.txcnt == '0 && c.mctl2[rq_pkg::B_EXIT]) begin
                    cn.st = idle_st;
                    cn.opmode[rq_pkg::B_TXON] = 1'b0;
                    set2[rq_pkg::B_TXEXIT] = 1'b1;
                end else if (mod_tx_take && c.txcnt != '0) begin
                    pop_tx  = 1'b1;
                    cn.txd  = c.txq[c.txrp];
                    cn.txv  = 1'b1;
                    cn.sent = c.sent + 8'h01;
                end
            end
            rq_pkg::ST_STANDBY, rq_pkg::ST_READY: begin
                cn.st = c.st;
            end
            default: begin
                cn.st = rq_pkg::ST_STANDBY;
            end
        endcase
        if (take) begin
            if (wfirst) begin
                cn.addr = wd[6:0];
                cn.wr   = wd[7];
                na      = wd[6:0];
                prep    = !wd[7];
            end else if (c.wr) begin
                case (c.addr)
                    rq_pkg::A_IEN1:   cn.ien1  = wd;
                    rq_pkg::A_IEN2:   cn.ien2  = wd;
                    rq_pkg::A_MCTL2:  cn.mctl2 = wd;
                    rq_pkg::A_PKLEN:  cn.pklen = wd;
                    rq_pkg::A_RXTHR:  cn.rxthr = wd[5:0];
                    rq_pkg::A_TXHI:   cn.txhi  = wd[5:0];
                    rq_pkg::A_TXLO:   cn.txlo  = wd[5:0];
                    rq_pkg::A_OPMODE: begin
                        cn.opmode = wd;
                        cn.sent   = 8'h00;
                        if (wd[rq_pkg::B_TXON]) begin
                            cn.st = rq_pkg::ST_TX;
                        end else if (wd[rq_pkg::B_READY]) begin
                            cn.st = rq_pkg::ST_READY;
                        end else begin
                            cn.st = rq_pkg::ST_STANDBY;
                        end
                    end
                    rq_pkg::A_QDATA:  push_tx = !tx_full;
                    default:          cn.addr = c.addr;
                endcase
                if (c.addr != rq_pkg::A_QDATA) begin
                    cn.addr = c.addr + 7'h01;
                end
            end else begin
                // read side effects land only once the byte has gone out
                // pop from receive queue
                pop_rx = (c.addr == rq_pkg::A_QDATA) && (c.rxcnt != '0);
                clr1   = (c.addr == rq_pkg::A_STAT1) ? c.rd_byte : 8'h00;
                clr2   = (c.addr == rq_pkg::A_STAT2) ? c.rd_byte : 8'h00;
                na     = (c.addr == rq_pkg::A_QDATA) ? c.addr : c.addr + 7'h01;
                cn.addr = na;
                prep    = 1'b1;
            end
        end
        push_rx = mod_rx_push && (c.rxcnt != CW'(QUEUE_DEPTH));
        if (push_tx) begin
            cn.txq[c.txwp] = wd;
            cn.txwp        = c.txwp + 1'b1;
        end
        if (pop_tx) begin
            cn.txrp = c.txrp + 1'b1;
        end
        if (push_rx) begin
            cn.rxq[c.rxwp] = mod_rx_data;
            cn.rxwp        = c.rxwp + 1'b1;
        end
        if (pop_rx) begin
            cn.rxrp = c.rxrp + 1'b1;
        end
        cn.txcnt = c.txcnt + CW'(push_tx) - CW'(pop_tx);
        cn.rxcnt = c.rxcnt + CW'(push_rx) - CW'(pop_rx);
        if (c.mctl2[rq_pkg::B_TXFLUSH]) begin
            cn.txwp  = '0;
            cn.txrp  = '0;
            cn.txcnt = '0;
        end
        if (c.mctl2[rq_pkg::B_RXFLUSH]) begin
            cn.rxwp  = '0;
            cn.rxrp  = '0;
            cn.rxcnt = '0;
        end
        set1[rq_pkg::B_TXAF] = (cn.txcnt > CW'(c.txhi)) && (c.txcnt <= CW'(c.txhi));
        set1[rq_pkg::B_TXAE] = pop_tx && (cn.txcnt < CW'(c.txlo)) && (c.txcnt >= CW'(c.txlo));
        set1[rq_pkg::B_RXAF] = (cn.rxcnt > CW'(c.rxthr)) && (c.rxcnt <= CW'(c.rxthr));
        // a flag set in the cycle of its clear survives
        cn.stat1 = (c.stat1 & ~clr1) | set1;
        cn.stat2 = (c.stat2 & ~clr2) | set2;
        if (prep) begin
            cn.rd_byte = reg_read(cn, na);
        end
        cn.irq_n = ~|((cn.stat1 & cn.ien1) | (cn.stat2 & cn.ien2));
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            c        <= '0;
            c.mctl2  <= rq_pkg::R_MCTL2;
            c.opmode <= rq_pkg::R_OPMODE;
            c.rxthr  <= rq_pkg::R_RXTHR;
            c.txhi   <= rq_pkg::R_TXHI;
            c.txlo   <= rq_pkg::R_TXLO;
            c.st     <= rq_pkg::ST_STANDBY;
            c.irq_n  <= 1'b1;
        end else begin
            c <= cn;
        end
    end

    // outputs straight from flops
    assign sdo              = l.sdo;
    assign sdo_oe           = l.oe;
    assign mod_tx_data      = c.txd;
    assign mod_tx_valid     = c.txv;
    assign radio_state      = c.st;
    assign interrupt_line_n = c.irq_n;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    tx_push_a: assert property (push_tx && !pop_tx && !c.mctl2[rq_pkg::B_TXFLUSH]
        |=> c.txcnt == $past(c.txcnt) + 1'b1) else $error("tx push not counted");
    rx_pop_a: assert property (pop_rx && !push_rx && !c.mctl2[rq_pkg::B_RXFLUSH]
        |=> c.rxcnt == $past(c.rxcnt) - 1'b1) else $error("rx pop not counted");
    tx_upper_a: assert property (c.txcnt == CW'(c.txhi) && push_tx && !pop_tx
        && !c.mctl2[rq_pkg::B_TXFLUSH] |=> c.stat1[rq_pkg::B_TXAF])
        else $error("tx upper event missed");
    tx_lower_a: assert property (c.txcnt == CW'(c.txlo) && pop_tx && !push_tx
        && c.txlo != 6'h00 |=> c.stat1[rq_pkg::B_TXAE]) else $error("tx lower event missed");
    rx_upper_a: assert property (c.rxcnt == CW'(c.rxthr) && push_rx && !pop_rx
        && !c.mctl2[rq_pkg::B_RXFLUSH] |=> c.stat1[rq_pkg::B_RXAF])
        else $error("rx upper event missed");
    empty_exit_a: assert property (c.st == rq_pkg::ST_TX && c.txcnt == '0
        && c.mctl2[rq_pkg::B_EXIT] && !mode_wr |=> c.st != rq_pkg::ST_TX)
        else $error("no exit on empty queue");
    pk_count_a: assert property (c.st == rq_pkg::ST_TX && c.pklen != 8'h00
        |-> c.sent <= c.pklen) else $error("sent past packet length");
    pk_end_a: assert property (pk_end && !mode_wr |=> c.stat1[rq_pkg::B_PKSENT]
        && c.st == ($past(c.opmode[rq_pkg::B_READY]) ? rq_pkg::ST_READY : rq_pkg::ST_STANDBY))
        else $error("wrong state after packet");
    flush_a: assert property (c.mctl2[rq_pkg::B_TXFLUSH] && c.mctl2[rq_pkg::B_RXFLUSH]
        |=> c.txcnt == '0 && c.rxcnt == '0) else $error("flush left data");
    irq_mask_a: assert property (((c.stat1 & c.ien1) | (c.stat2 & c.ien2)) == 8'h00
        |-> c.irq_n) else $error("masked flag drove line");
    irq_hold_a: assert property ((c.stat1 & c.ien1) != 8'h00 |-> !c.irq_n)
        else $error("pending flag not on line");
    full_hold_a: assert property (tx_wr && take && tx_full
        && !c.mctl2[rq_pkg::B_TXFLUSH] |=> $stable(c.txwp)) else $error("full write moved");
    count_a: assert property (c.txcnt[PW-1:0] == PW'(c.txwp - c.txrp))
        else $error("tx count off pointers");
endmodule // rq_byte_queues

// [sim/rq_host_model.sv]
module rq_host_model (
    // serial pins
    output logic      sck,
    output logic      sel_n,
    output logic      sdi,
    input  wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ps;

    // link clock stands still outside frames
    initial begin
        sck = 1'b0;
        sel_n = 1'b1;
        sdi = 1'b0;
    end

    // one byte msb first, sdo sampled on the falling edge
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sdi = tx[i];
            #7.5 sck = 1'b1;
            #7.5 sck = 1'b0;
            rx[i] = sdo;
        end
        sdi = ~sdi;  // released line shows no stale level
    endtask

    // whole frame; a read waits with sck still so the core can hand over a byte
    task automatic frame(input logic wr, input logic [6:0] a, ref logic [7:0] d[$]);
        logic [7:0] r;
        sel_n = 1'b0;
        #20 xfer({wr, a}, r);
        foreach (d[i]) begin
            if (!wr) #1200;
            xfer(d[i], r);
            if (!wr) d[i] = r;
        end
        #20 sel_n = 1'b1;
        #30;
    endtask
endmodule // rq_host_model

// [sim/radio_tx_rx_byte_queues_tb_top.sv]
module radio_tx_rx_byte_queues_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, reset_n = 1'b0, sck, sel_n, sdi, sdo, sdo_oe, irq_n;
    logic       mod_tx_take = 1'b0, mod_tx_valid, mod_rx_push = 1'b0;
    logic [7:0] mod_tx_data, mod_rx_data = 8'h00;
    logic [1:0] radio_state;
    logic [7:0] exp_q[$], exp_rx[$], d[$];
    int         n_errors = 0, n_compared = 0;
    int         seed = 32'h1b62ba79;
    int         n_bit = 0;
    logic       rd_frame = 1'b0;

    always #50 clk = ~clk;

    rq_byte_queues dut (.clk(clk), .reset_n(reset_n), .sck(sck), .sel_n(sel_n), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe), .mod_tx_take(mod_tx_take), .mod_tx_data(mod_tx_data),
        .mod_tx_valid(mod_tx_valid), .mod_rx_push(mod_rx_push), .mod_rx_data(mod_rx_data),
        .radio_state(radio_state), .interrupt_line_n(irq_n));
    rq_host_model host (.sck(sck), .sel_n(sel_n), .sdi(sdi), .sdo(sdo));

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want) begin
            n_errors++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic test_done();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // register access, leaving time for the write to cross
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        d = '{v};
        host.frame(1'b1, a, d);
        #1000;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] want);
        d = '{8'h00};
        host.frame(1'b0, a, d);
        check(d[0], want);
    endtask

    // modem takes bytes while transmitting; bounded
    task automatic modem_tx();
        int k;
        k = 0;
        while (radio_state === 2'd2 && k < 100) begin
            @(posedge clk) #5 mod_tx_take = 1'b1;
            @(posedge clk) #5 mod_tx_take = 1'b0;
            repeat (2) @(posedge clk);
            k++;
        end
        if (k == 100) begin
            n_errors++;
            test_done();
        end
    endtask

    // sent bytes are compared as they appear; mid-cycle, clear of the launching edge
    always @(negedge clk) begin
        if (mod_tx_valid === 1'b1) begin
            check(mod_tx_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
        end
    end

    // drive enable: high from the end of a read address byte until release
    always @(negedge sel_n) n_bit = 0;
    always @(posedge sck) begin
        n_bit++;
        if (n_bit == 1) rd_frame = !sdi;
    end
    always @(negedge sck) begin
        if (sel_n === 1'b0) check({7'h00, sdo_oe}, {7'h00, rd_frame && n_bit >= 8});
    end

    initial begin
        #3000000;
        n_errors++;
        test_done();
    end

    initial begin
        repeat (6) @(posedge clk);
        #5 reset_n = 1'b1;
        repeat (4) @(posedge clk);
        // ----------------------------------------
        // reset values, unmapped place
        // ----------------------------------------
        rd(rq_pkg::A_RXTHR, 8'h37);
        rd(rq_pkg::A_TXHI, 8'h37);
        rd(rq_pkg::A_TXLO, 8'h04);
        rd(rq_pkg::A_MCTL2, 8'h00);
        wr(7'h10, 8'h5A);
        rd(7'h10, 8'h00);
        // ----------------------------------------
        // packets of set length, disabled events
        // ----------------------------------------
        wr(rq_pkg::A_TXHI, 8'h02);
        d = {};
        repeat (5) d.push_back(8'($random(seed)));
        exp_q = d;
        host.frame(1'b1, rq_pkg::A_QDATA, d);
        #1000 check({7'h00, irq_n}, 8'h01);
        wr(rq_pkg::A_PKLEN, 8'h03);
        wr(rq_pkg::A_OPMODE, 8'h09);
        modem_tx();
        check({6'h00, radio_state}, 8'h01);
        check(8'(exp_q.size()), 8'h02);
        rd(rq_pkg::A_STAT1, 8'h64);
        wr(rq_pkg::A_PKLEN, 8'h02);
        wr(rq_pkg::A_OPMODE, 8'h08);
        modem_tx();
        check({6'h00, radio_state}, 8'h00);
        check(8'(exp_q.size()), 8'h00);
        // ----------------------------------------
        // flush, then exit on an empty queue
        // ----------------------------------------
        d = '{8'h11, 8'h22};
        host.frame(1'b1, rq_pkg::A_QDATA, d);
        wr(rq_pkg::A_MCTL2, 8'h01);
        wr(rq_pkg::A_MCTL2, 8'h08);
        wr(rq_pkg::A_PKLEN, 8'h00);
        wr(rq_pkg::A_OPMODE, 8'h08);
        modem_tx();
        check({6'h00, radio_state}, 8'h00);
        rd(rq_pkg::A_STAT2, 8'h80);
        // ----------------------------------------
        // full queue drops the extra byte, then drains to exit
        // ----------------------------------------
        d = {};
        repeat (65) d.push_back(8'($random(seed)));
        exp_q = d[0:63];
        host.frame(1'b1, rq_pkg::A_QDATA, d);
        wr(rq_pkg::A_OPMODE, 8'h08);
        modem_tx();
        check({6'h00, radio_state}, 8'h00);
        check(8'(exp_q.size()), 8'h00);
        // ----------------------------------------
        // receive threshold, line, drain
        // ----------------------------------------
        wr(rq_pkg::A_RXTHR, 8'h03);
        wr(rq_pkg::A_IEN1, 8'h10);
        repeat (4) begin
            @(posedge clk) #5 mod_rx_data = 8'($random(seed));
            mod_rx_push = 1'b1;
            exp_rx.push_back(mod_rx_data);
            @(posedge clk) #5 mod_rx_push = 1'b0;
        end
        repeat (3) @(posedge clk);
        check({7'h00, irq_n}, 8'h00);
        d = '{8'h00, 8'h00, 8'h00, 8'h00};
        // host drains after the event
        host.frame(1'b0, rq_pkg::A_QDATA, d);
        foreach (d[i]) check(d[i], exp_rx.pop_front());
        rd(rq_pkg::A_STAT1, 8'h74);
        #1000 check({7'h00, irq_n}, 8'h01);
        rd(rq_pkg::A_QDATA, 8'h00);
        // receive flush discards what arrived
        repeat (2) begin
            @(posedge clk) #5 mod_rx_data = 8'hA5;
            mod_rx_push = 1'b1;
            @(posedge clk) #5 mod_rx_push = 1'b0;
        end
        wr(rq_pkg::A_MCTL2, 8'h03);
        wr(rq_pkg::A_MCTL2, 8'h00);
        rd(rq_pkg::A_QDATA, 8'h00);
        test_done();
    end
endmodule // radio_tx_rx_byte_queues_tb_top
